//--- hdl/pcd_prescaler.sv
// PWM input clock prescaler: emits one tick every 1..64 clocks
`timescale 1ns/10ps
module pcd_prescaler (
   input  wire logic  pclk,
   input  wire logic  presetn,
   pcd_tick_if.src    tk
);

   pcd_pkg::pcd_div_state_e state;
   pcd_pkg::pcd_div_state_e next_state;
   logic [5:0]              cnt;
   logic [5:0]              next_cnt;
   logic                    tick;
   logic                    next_tick;

   // Terminal count for a code; reserved code stops ticks
   function automatic logic [6:0] div_ratio(input logic [2:0] code);
      if (code == pcd_pkg::DIV_RESERVED) begin
         div_ratio = 7'h00;
      end else begin
         div_ratio = 7'(7'h01 << code);
      end
   endfunction : div_ratio

   ////////////////////////////////////////////////////////////////
   // Next state: count while the time base runs
   always_comb begin
      logic [6:0] ratio;
      ratio      = div_ratio(tk.sel);
      next_state = state;
      next_cnt   = cnt;
      next_tick  = 1'b0;
      unique case (state)
         pcd_pkg::PCD_DIV_IDLE: begin
            next_cnt = 6'h00;
            if (tk.run) begin
               next_state = pcd_pkg::PCD_DIV_RUN;
            end
         end
         pcd_pkg::PCD_DIV_RUN: begin
            if (!tk.run) begin
               next_state = pcd_pkg::PCD_DIV_IDLE;
            end else if (ratio != 7'h00) begin
               if ({1'b0, cnt} + 7'h01 >= ratio) begin
                  next_cnt  = 6'h00;
                  next_tick = 1'b1;
               end else begin
                  next_cnt = cnt + 6'h01;
               end
            end
         end
         default: begin
            next_state = pcd_pkg::PCD_DIV_IDLE;
         end
      endcase
   end

   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= pcd_pkg::PCD_DIV_IDLE;
         cnt   <= 6'h00;
         tick  <= 1'b0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         tick  <= next_tick;
      end
   end

   assign tk.tick = tick;

endmodule : pcd_prescaler

//--- hdl/pcd_top.sv
// PWM clock prescaler, special event postscaler and per-channel output chopping with APB registers
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module pcd_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  pwm_high_raw,
   input  wire logic [2:0]  pwm_low_raw,
   input  wire logic        compare_match,
   input  wire logic        external_sync_input,
   output logic             time_base_on,
   output logic             prescaled_tick,
   output logic             special_event_trigger,
   output logic             sync_seen,
   output logic [2:0]       channel_high_output,
   output logic [2:0]       channel_low_output,
   output logic [2:0]       hires_period_disable,
   output logic [2:0]       hires_duty_disable
);

   pcd_tick_if tk ();

   logic [2:0]  pwm_clock_divide_select;
   logic [2:0]  next_pwm_clock_divide_select;
   logic [15:0] pwm_channel_aux_control [pcd_pkg::NUM_CH];
   logic [15:0] next_aux [pcd_pkg::NUM_CH];
   logic [15:0] special_ctrl;
   logic [15:0] next_special_ctrl;
   logic [9:0]  chopgen_half;
   logic [9:0]  next_chopgen_half;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic        next_pready;
   logic [2:0]  sync_ff;
   logic [2:0]  next_sync_ff;
   logic [2:0]  high_sync1, high_sync2;
   logic [2:0]  low_sync1,  low_sync2;
   logic        cm_sync1,   cm_sync2, cm_prev;
   logic [3:0]  post_cnt;
   logic [3:0]  next_post_cnt;
   logic        next_trigger;
   logic [9:0]  gen_cnt;
   logic [9:0]  next_gen_cnt;
   logic        gen_clk;
   logic        next_gen_clk;
   logic        next_tick_out;
   logic [2:0]  next_high, next_low, next_hrp, next_hrd;
   logic        next_sync_seen;
   logic        bus_write;
   logic        bus_read;

   // Chop signal for a source code; reserved codes hold chop-enabled outputs off
   function automatic logic chop_pick(input logic [3:0] code, input logic gen, input logic [2:0] hi);
      unique case (code)
         pcd_pkg::CHOP_GEN: chop_pick = gen;
         pcd_pkg::CHOP_CH1: chop_pick = hi[0];
         pcd_pkg::CHOP_CH2: chop_pick = hi[1];
         pcd_pkg::CHOP_CH3: chop_pick = hi[2];
         default:           chop_pick = 1'b0;
      endcase
   endfunction : chop_pick

   // Word offset match helper
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   ////////////////////////////////////////////////////////////////
   // Prescaler: runs only while the time base is on
   assign tk.run = special_ctrl[pcd_pkg::TB_ON_BIT];
   assign tk.sel = pwm_clock_divide_select;

   pcd_prescaler u_pre (
      .pclk    (pclk),
      .presetn (presetn),
      .tk      (tk)
   );

   ////////////////////////////////////////////////////////////////
   // APB slave: one wait state; a write lands at the edge that sees pready
   assign bus_write = psel & penable & pwrite & pready;
   assign bus_read  = psel & ~penable & ~pwrite;

   always_comb begin
      next_pwm_clock_divide_select = pwm_clock_divide_select;
      next_special_ctrl            = special_ctrl;
      next_chopgen_half            = chopgen_half;
      for (int i = 0; i < pcd_pkg::NUM_CH; i++) begin
         next_aux[i] = pwm_channel_aux_control[i];
      end
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      next_pready  = 1'b0;
      if (bus_write) begin
         if (hit(paddr, pcd_pkg::PRESCALE_OFFSET)) begin
            // Intended to change only while stopped; not enforced in hardware
            next_pwm_clock_divide_select = pwdata[pcd_pkg::DIV_MSB:pcd_pkg::DIV_LSB];
         end else if (hit(paddr, pcd_pkg::AUX1_OFFSET)) begin
            next_aux[0] = pwdata[15:0] & pcd_pkg::AUX_WMASK;
         end else if (hit(paddr, pcd_pkg::AUX2_OFFSET)) begin
            next_aux[1] = pwdata[15:0] & pcd_pkg::AUX_WMASK;
         end else if (hit(paddr, pcd_pkg::AUX3_OFFSET)) begin
            next_aux[2] = pwdata[15:0] & pcd_pkg::AUX_WMASK;
         end else if (hit(paddr, pcd_pkg::SPECIAL_OFFSET)) begin
            next_special_ctrl = {pwdata[15], 11'h000, pwdata[3:0]};
         end else if (hit(paddr, pcd_pkg::CHOPGEN_OFFSET)) begin
            next_chopgen_half = (pwdata[9:0] == 10'h000) ? 10'h001 : pwdata[9:0];
         end
      end
      // Ready is a single pulse; an access held past it is answered again two cycles later
      if (psel & penable & ~pready) begin
         next_pready = 1'b1;
      end
      // Read data captured in setup so it is valid at the access edge
      if (bus_read) begin
         next_prdata = 32'h0000_0000;
         if (hit(paddr, pcd_pkg::PRESCALE_OFFSET)) begin
            next_prdata = {29'h0000_0000, pwm_clock_divide_select};
         end else if (hit(paddr, pcd_pkg::AUX1_OFFSET)) begin
            next_prdata = {16'h0000, pwm_channel_aux_control[0]};
         end else if (hit(paddr, pcd_pkg::AUX2_OFFSET)) begin
            next_prdata = {16'h0000, pwm_channel_aux_control[1]};
         end else if (hit(paddr, pcd_pkg::AUX3_OFFSET)) begin
            next_prdata = {16'h0000, pwm_channel_aux_control[2]};
         end else if (hit(paddr, pcd_pkg::SPECIAL_OFFSET)) begin
            next_prdata = {16'h0000, special_ctrl};
         end else if (hit(paddr, pcd_pkg::CHOPGEN_OFFSET)) begin
            next_prdata = {22'h00_0000, chopgen_half};
         end else if (hit(paddr, pcd_pkg::STATUS_OFFSET)) begin
            next_prdata = {24'h00_0000, channel_low_output, channel_high_output,
                           gen_clk, sync_seen};
         end
      end
      if (psel & penable & ~pready) begin
         next_pslverr = ~(hit(paddr, pcd_pkg::PRESCALE_OFFSET) | hit(paddr, pcd_pkg::AUX1_OFFSET)
                        | hit(paddr, pcd_pkg::AUX2_OFFSET) | hit(paddr, pcd_pkg::AUX3_OFFSET)
                        | hit(paddr, pcd_pkg::SPECIAL_OFFSET) | hit(paddr, pcd_pkg::CHOPGEN_OFFSET)
                        | hit(paddr, pcd_pkg::STATUS_OFFSET));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_clock_divide_select <= pcd_pkg::DIV_RESET;
         special_ctrl            <= pcd_pkg::SPECIAL_RESET;
         chopgen_half            <= pcd_pkg::CHOPGEN_RESET;
         for (int i = 0; i < pcd_pkg::NUM_CH; i++) begin
            pwm_channel_aux_control[i] <= pcd_pkg::AUX_RESET;
         end
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         pwm_clock_divide_select <= next_pwm_clock_divide_select;
         special_ctrl            <= next_special_ctrl;
         chopgen_half            <= next_chopgen_half;
         for (int i = 0; i < pcd_pkg::NUM_CH; i++) begin
            pwm_channel_aux_control[i] <= next_aux[i];
         end
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
         pready  <= next_pready;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Pin inputs: two-flop synchronisers before any logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_sync1 <= 3'h0;
         high_sync2 <= 3'h0;
         low_sync1  <= 3'h0;
         low_sync2  <= 3'h0;
         cm_sync1   <= 1'b0;
         cm_sync2   <= 1'b0;
         cm_prev    <= 1'b0;
         sync_ff    <= 3'h0;
      end else begin
         high_sync1 <= pwm_high_raw;
         high_sync2 <= high_sync1;
         low_sync1  <= pwm_low_raw;
         low_sync2  <= low_sync1;
         cm_sync1   <= compare_match;
         cm_sync2   <= cm_sync1;
         cm_prev    <= cm_sync2;
         sync_ff    <= next_sync_ff;
      end
   end

   assign next_sync_ff = {sync_ff[1], sync_ff[0], external_sync_input};

   ////////////////////////////////////////////////////////////////
   // Postscaler, chop generator and output gating
   always_comb begin
      logic       cm_edge;
      logic       chop;
      logic [3:0] ratio_m1;
      chop          = 1'b0;
      cm_edge       = cm_sync2 & ~cm_prev & tk.run;
      ratio_m1      = special_ctrl[pcd_pkg::POST_MSB:pcd_pkg::POST_LSB];
      next_post_cnt = post_cnt;
      next_trigger  = 1'b0;
      if (!tk.run) begin
         next_post_cnt = 4'h0;
      end else if (cm_edge) begin
         if (ratio_m1 == pcd_pkg::POST_ONE || post_cnt >= ratio_m1) begin
            next_trigger  = 1'b1;
            next_post_cnt = 4'h0;
         end else begin
            next_post_cnt = post_cnt + 4'h1;
         end
      end
      // Sync is only recorded; period margin is software's job
      next_sync_seen = sync_ff[1] & ~sync_ff[2] & tk.run;
      next_gen_cnt   = gen_cnt;
      next_gen_clk   = gen_clk;
      if (!tk.run) begin
         next_gen_cnt = 10'h000;
         next_gen_clk = 1'b0;
      end else if (tk.tick) begin
         if (gen_cnt + 10'h001 >= chopgen_half) begin
            next_gen_cnt = 10'h000;
            next_gen_clk = ~gen_clk;
         end else begin
            next_gen_cnt = gen_cnt + 10'h001;
         end
      end
      next_tick_out = tk.tick;
      for (int i = 0; i < pcd_pkg::NUM_CH; i++) begin
         chop = chop_pick(pwm_channel_aux_control[i][pcd_pkg::CHOPSRC_MSB:pcd_pkg::CHOPSRC_LSB],
                          gen_clk, high_sync2);
         next_high[i] = high_sync2[i] & (~pwm_channel_aux_control[i][pcd_pkg::HCHOP_BIT] | chop);
         next_low[i]  = low_sync2[i]  & (~pwm_channel_aux_control[i][pcd_pkg::LCHOP_BIT] | chop);
         next_hrp[i]  = pwm_channel_aux_control[i][pcd_pkg::HRP_DIS_BIT];
         next_hrd[i]  = pwm_channel_aux_control[i][pcd_pkg::HRD_DIS_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         post_cnt              <= 4'h0;
         special_event_trigger <= 1'b0;
         sync_seen             <= 1'b0;
         gen_cnt               <= 10'h000;
         gen_clk               <= 1'b0;
         prescaled_tick        <= 1'b0;
         time_base_on          <= 1'b0;
         channel_high_output   <= 3'h0;
         channel_low_output    <= 3'h0;
         hires_period_disable  <= 3'h0;
         hires_duty_disable    <= 3'h0;
      end else begin
         post_cnt              <= next_post_cnt;
         special_event_trigger <= next_trigger;
         sync_seen             <= next_sync_seen;
         gen_cnt               <= next_gen_cnt;
         gen_clk               <= next_gen_clk;
         prescaled_tick        <= next_tick_out;
         time_base_on          <= tk.run;
         channel_high_output   <= next_high;
         channel_low_output    <= next_low;
         hires_period_disable  <= next_hrp;
         hires_duty_disable    <= next_hrd;
      end
   end

endmodule : pcd_top

//--- inc/pcd_pkg.sv
// Package of register offsets, field positions, reset values and codes for the PWM clock/chop block
package pcd_pkg;

   // Register byte offsets on APB
   localparam logic [11:0] PRESCALE_OFFSET  = 12'h000;
   localparam logic [11:0] AUX1_OFFSET      = 12'h004;
   localparam logic [11:0] AUX2_OFFSET      = 12'h008;
   localparam logic [11:0] AUX3_OFFSET      = 12'h00C;
   localparam logic [11:0] SPECIAL_OFFSET   = 12'h010;
   localparam logic [11:0] STATUS_OFFSET    = 12'h014;
   localparam logic [11:0] CHOPGEN_OFFSET   = 12'h018;

   // Clock divider register fields
   localparam int          DIV_LSB          = 0;
   localparam int          DIV_MSB          = 2;
   localparam logic [2:0]  DIV_RESET        = 3'h0;
   localparam logic [2:0]  DIV_RESERVED     = 3'h7;

   // Auxiliary control fields
   localparam int          HRP_DIS_BIT      = 15;
   localparam int          HRD_DIS_BIT      = 14;
   localparam int          BLANK_LSB        = 8;
   localparam int          BLANK_MSB        = 11;
   localparam int          CHOPSRC_LSB      = 2;
   localparam int          CHOPSRC_MSB      = 5;
   localparam int          HCHOP_BIT        = 1;
   localparam int          LCHOP_BIT        = 0;
   localparam logic [15:0] AUX_WMASK        = 16'hCF3F;
   localparam logic [15:0] AUX_RESET        = 16'h0000;

   // Chop source codes
   localparam logic [3:0]  CHOP_GEN         = 4'h0;
   localparam logic [3:0]  CHOP_CH1         = 4'h1;
   localparam logic [3:0]  CHOP_CH2         = 4'h2;
   localparam logic [3:0]  CHOP_CH3         = 4'h3;

   // Special event control: bit 15 time_base_on, bits 3:0 postscale
   localparam int          TB_ON_BIT        = 15;
   localparam int          POST_LSB         = 0;
   localparam int          POST_MSB         = 3;
   localparam logic [3:0]  POST_ONE         = 4'h0;
   localparam logic [15:0] SPECIAL_RESET    = 16'h0000;

   // Chop clock generator half period in prescaled ticks
   localparam logic [9:0]  CHOPGEN_RESET    = 10'h001;

   localparam int          NUM_CH           = 3;

   // Divider state machine
   typedef enum logic [1:0] {
      PCD_DIV_IDLE = 2'b01,
      PCD_DIV_RUN  = 2'b10
   } pcd_div_state_e;

endpackage : pcd_pkg

//--- inc/pcd_tick_if.sv
// Interface carrying the prescaled tick between the divider and the main block
`timescale 1ns/10ps
interface pcd_tick_if;
   logic       run;
   logic [2:0] sel;
   logic       tick;
   modport src (input run, input sel, output tick);
   modport dst (output run, output sel, input tick);
endinterface : pcd_tick_if

//--- tb/pcd_switch_model.sv
// Power stage model: gate driver and switch of the channel 1 high side
`timescale 1ns/10ps
module pcd_switch_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [2:0]  gate_high,
   output logic      [15:0] turn_ons
);
   logic [2:0] prev_high;
   ////////////////////////////////////////////////////////////////////////////////
   // Counts switch turn-on events; chopping shows as many short on-times
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_high <= 3'h0;
         turn_ons  <= 16'h0;
      end else begin
         prev_high <= gate_high;
         if (gate_high[0] && !prev_high[0]) begin
            turn_ons <= turn_ons + 16'h1;
         end
      end
   end
endmodule : pcd_switch_model

//--- tb/pcd_top_monitor.sv
// Checker of bus handshake, tick, trigger and output gating at the top ports
`timescale 1ns/10ps
module pcd_top_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [2:0]  pwm_high_raw,
   input wire logic [2:0]  pwm_low_raw,
   input wire logic        compare_match,
   input wire logic        time_base_on,
   input wire logic        prescaled_tick,
   input wire logic        special_event_trigger,
   input wire logic        sync_seen,
   input wire logic [2:0]  channel_high_output,
   input wire logic [2:0]  channel_low_output
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Bus answers only in the second access cycle, for one cycle
   a_ready_in_access: assert property (pready |-> psel && penable && $past(psel) && $past(penable))
      else $error("ready outside second access cycle");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_div_upper_zero: assert property (pready && !pwrite && paddr == pcd_pkg::PRESCALE_OFFSET |-> prdata[31:3] == '0)
      else $error("divider upper bits not zero");
   ////////////////////////////////////////////////////////////////////////////////
   // Time base events; lags allow for the two-flop input synchronisers
   a_tick_when_on: assert property (prescaled_tick |-> time_base_on || $past(time_base_on))
      else $error("tick with time base off");
   a_trig_one_pulse: assert property (special_event_trigger |=> !special_event_trigger)
      else $error("trigger longer than one cycle");
   a_trig_has_cause: assert property (special_event_trigger |->
      $past(compare_match, 3) || $past(compare_match, 4) || $past(compare_match, 5))
      else $error("trigger without compare match");
   a_sync_one_pulse: assert property (sync_seen |=> !sync_seen) else $error("sync pulse too long");
   ////////////////////////////////////////////////////////////////////////////////
   // Chopping may only remove pulses, never create them
   a_high_gated_raw: assert property ((channel_high_output & ~($past(pwm_high_raw, 2) |
      $past(pwm_high_raw, 3) | $past(pwm_high_raw, 4))) == 3'h0)
      else $error("high output without raw pulse");
   a_low_gated_raw: assert property ((channel_low_output & ~($past(pwm_low_raw, 2) |
      $past(pwm_low_raw, 3) | $past(pwm_low_raw, 4))) == 3'h0)
      else $error("low output without raw pulse");
   c_refused: cover property (pready && pslverr);
   c_trigger: cover property (special_event_trigger);
   c_tick: cover property (prescaled_tick);
endmodule : pcd_top_monitor

//--- tb/pcd_top_tb_top.sv
// Top testbench: register, prescaler, trigger and chopping scenarios over APB
`timescale 1ns/10ps
module pcd_top_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        compare_match, external_sync_input, time_base_on;
   logic        prescaled_tick, special_event_trigger, sync_seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  pwm_high_raw, pwm_low_raw, channel_high_output, channel_low_output;
   logic [2:0]  hires_period_disable, hires_duty_disable;
   logic [15:0] turn_ons, t0;
   int          n_fail = 0, comparisons = 0, cyc = 0, n;

   pcd_top i_pcd_top (.*);
   pcd_switch_model i_pcd_switch_model (.pclk(pclk), .presetn(presetn), .gate_high(channel_high_output),
      .turn_ons(turn_ons));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Hang guard; a full run takes about 1500 cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; request held until ready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      chk(pready, 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk

   task automatic cycles(input int c);
      repeat (c) @(posedge pclk);
   endtask : cycles
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pwm_high_raw = 3'h0;
      pwm_low_raw = 3'h0;
      compare_match = 1'b0;
      external_sync_input = 1'b0;
      cycles(3);
      presetn <= 1'b1;
      rchk(pcd_pkg::PRESCALE_OFFSET, 32'h0);
      rchk(pcd_pkg::AUX1_OFFSET, 32'h0);
      apb(1'b1, pcd_pkg::PRESCALE_OFFSET, 32'hFFFF_FFFF);
      rchk(pcd_pkg::PRESCALE_OFFSET, 32'h7);
      apb(1'b1, pcd_pkg::AUX1_OFFSET, 32'h0000_FFFF);
      rchk(pcd_pkg::AUX1_OFFSET, 32'h0000_CF3F);
      chk({26'h0, hires_period_disable, hires_duty_disable}, 32'h9);
      apb(1'b1, pcd_pkg::AUX1_OFFSET, 32'h0000_4000);
      cycles(2);
      chk({26'h0, hires_period_disable, hires_duty_disable}, 32'h1);
      // Refused accesses at an unmapped word
      apb(1'b1, 12'h01C, 32'hFFFF);
      chk(err, 1'b1);
      apb(1'b0, 12'h01C, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      // Divider only changed while the time base is off
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, pcd_pkg::SPECIAL_OFFSET, 32'h0);
         apb(1'b1, pcd_pkg::PRESCALE_OFFSET, c);
         apb(1'b1, pcd_pkg::SPECIAL_OFFSET, 32'h8000);
         cycles(4);
         n = 0;
         repeat (128) begin
            @(posedge pclk);
            if (prescaled_tick === 1'b1) n++;
         end
         chk(n, (c == 7) ? 0 : (128 >> c));
      end
      apb(1'b1, pcd_pkg::SPECIAL_OFFSET, 32'h0);
      apb(1'b1, pcd_pkg::PRESCALE_OFFSET, 32'h0);
      // Postscale codes 0 and 1 over four matches
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, pcd_pkg::SPECIAL_OFFSET, 32'h8000 | p);
         n = 0;
         for (int m = 0; m < 8; m++) begin
            compare_match <= ~m[0];
            repeat (6) begin
               @(posedge pclk);
               if (special_event_trigger === 1'b1) n++;
            end
         end
         chk(n, 4 / (p + 1));
      end
      chk(time_base_on, 1'b1);
      external_sync_input <= 1'b1;
      n = 0;
      repeat (8) begin
         @(posedge pclk);
         if (sync_seen === 1'b1) n++;
      end
      external_sync_input <= 1'b0;
      chk(n, 1);
      // Chop clock generator toggles an enabled high output; zero half period reads as one
      apb(1'b1, pcd_pkg::CHOPGEN_OFFSET, 32'h0);
      rchk(pcd_pkg::CHOPGEN_OFFSET, 32'h1);
      apb(1'b1, pcd_pkg::AUX1_OFFSET, 32'h0002);
      pwm_high_raw <= 3'h7;
      cycles(4);
      t0 = turn_ons;
      cycles(64);
      chk(16'(turn_ons - t0), 16'h0020);
      apb(1'b1, pcd_pkg::AUX1_OFFSET, 32'h0);
      // Channel high outputs as chop source for channel 2
      for (int c = 1; c < 4; c++) begin
         apb(1'b1, pcd_pkg::AUX2_OFFSET, (c << 2) | 2);
         for (int v = 0; v < 2; v++) begin
            pwm_high_raw <= v ? 3'(3'b010 | (1 << (c - 1))) : 3'(3'b010 & ~(1 << (c - 1)));
            cycles(5);
            chk(channel_high_output[1], v);
         end
      end
      // Reserved codes leave enabled outputs off
      for (int c = 4; c < 10; c++) begin
         apb(1'b1, pcd_pkg::AUX2_OFFSET, (c << 2) | 2);
         pwm_high_raw <= 3'h7;
         cycles(5);
         chk(channel_high_output, 3'b101);
      end
      apb(1'b1, pcd_pkg::AUX2_OFFSET, 32'h0);
      apb(1'b1, pcd_pkg::AUX3_OFFSET, 32'h0005);
      pwm_low_raw <= 3'h7;
      pwm_high_raw <= 3'b110;
      cycles(5);
      chk(channel_low_output, 3'b011);
      chk(channel_high_output, 3'b110);
      pwm_high_raw <= 3'h7;
      cycles(5);
      chk(channel_low_output, 3'b111);
      conclude();
   end
endmodule : pcd_top_tb_top

bind pcd_top pcd_top_monitor i_pcd_top_monitor (.*);
